// ### ddr2_cmd_addr_decode.sv
// Purpose: Command and address input stage of an eight-bank x8 DDR2 device.
// Assumes: All pins arrive from outside the clock domain and are synchronised here.
// Notes: Data path, mode registers, refresh and power-down timing are handled elsewhere.
`timescale 1ns/1ns
`default_nettype none

module ddr2_cmd_addr_decode #(
  parameter int BURST_CYCLES = ddr2_cmd_pkg::AP_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command and address pins
  input wire ddr2_cmd_pkg::cmd_pins_t pins,
  // Write mask pin and the beat strobe from data capture
  input wire logic dm,
  input wire logic beatStrobe,
  // Decoded command, one-cycle pulses with their fields
  output var ddr2_cmd_pkg::dec_cmd_t cmdOut,
  // Bank and clock status
  output logic [ddr2_cmd_pkg::NUM_BANKS-1:0] bankOpen,
  output var ddr2_cmd_pkg::pwr_state_t pwrState,
  output logic clkActive,
  // Write beat verdict
  output logic beatKeep,
  output logic beatDiscard
);
  import ddr2_cmd_pkg::*;

  localparam int CW = $clog2(BURST_CYCLES + 1);
  localparam int AP_MAX = BURST_CYCLES + 1;
  localparam logic [CW-1:0] AP_LOAD = CW'(BURST_CYCLES);
  localparam logic [CW-1:0] AP_ONE = CW'(1);
  localparam logic [CW-1:0] AP_ZERO = '0;

  // ==========================================================================
  // Pin synchronisers
  cmd_pins_t pinsS1_reg;
  cmd_pins_t pinsS2_reg;
  logic dmS1_reg;
  logic dmS2_reg;
  logic beatS1_reg;
  logic beatS2_reg;

  // Two stages on every pin; only the second stage feeds the decoder.
  always_ff @(posedge clk) begin
    if (rst) begin
      pinsS1_reg <= PINS_IDLE;
      pinsS2_reg <= PINS_IDLE;
    end else begin
      pinsS1_reg <= pins; // RL1
      pinsS2_reg <= pinsS1_reg; // RL1
    end
  end

  // The mask and strobe travel the same two stages so they stay aligned.
  always_ff @(posedge clk) begin
    if (rst) begin
      dmS1_reg <= 1'b0;
      dmS2_reg <= 1'b0;
      beatS1_reg <= 1'b0;
      beatS2_reg <= 1'b0;
    end else begin
      dmS1_reg <= dm;
      dmS2_reg <= dmS1_reg;
      beatS1_reg <= beatStrobe;
      beatS2_reg <= beatS1_reg;
    end
  end

  // ==========================================================================
  // Clock state through CKE
  pwr_state_t pwrState_reg;
  pwr_state_t pwrState_next;
  cmd_t cmdCode;
  wire ckeHigh = pinsS2_reg.cke;
  wire csLow = !pinsS2_reg.csN;
  wire refreshCode = (cmdCode == CMD_REFRESH);

  assign cmdCode = cmd_t'({pinsS2_reg.rasN, pinsS2_reg.casN, pinsS2_reg.weN}); // RL5

  // Dropping CKE with a refresh code and chip select low enters self-refresh; otherwise power-down.
  always_comb begin
    pwrState_next = pwrState_reg;
    case (pwrState_reg)
      PWR_ACTIVE: begin
        if (!ckeHigh) begin
          pwrState_next = (csLow && refreshCode) ? PWR_SELF_REFRESH : PWR_DOWN; // RL2
        end
      end
      PWR_DOWN, PWR_SELF_REFRESH: begin
        if (ckeHigh) begin
          pwrState_next = PWR_ACTIVE; // RL2
        end
      end
      default: begin
        pwrState_next = PWR_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwrState_reg <= PWR_ACTIVE;
    end else begin
      pwrState_reg <= pwrState_next;
    end
  end

  // ==========================================================================
  // Command decode
  // The decoder only listens while the clock is live and chip select is low.
  wire decodeEn = ckeHigh && csLow; // RL2 RL3 RL4
  wire isAct = decodeEn && (cmdCode == CMD_ACTIVATE); // RL5
  wire isRd = decodeEn && (cmdCode == CMD_READ); // RL5
  wire isWr = decodeEn && (cmdCode == CMD_WRITE); // RL5
  wire isPre = decodeEn && (cmdCode == CMD_PRECHARGE); // RL5
  wire apBit = pinsS2_reg.addr[AP_BIT];
  wire isAccess = isRd || isWr;
  wire [BA_W-1:0] bankAddr = pinsS2_reg.bank; // RL11
  wire [ROW_W-1:0] rowAddr = pinsS2_reg.addr; // RL6
  wire [COL_W-1:0] colAddr = pinsS2_reg.addr[COL_W-1:0]; // RL7
  wire [NUM_BANKS-1:0] bankHit = NUM_BANKS'(1) << bankAddr; // RL11
  dec_cmd_t cmd_reg;
  dec_cmd_t cmd_next;

  // Fields are held between commands; only the strobes return to zero.
  always_comb begin
    cmd_next = cmd_reg;
    cmd_next.act = isAct;
    cmd_next.rd = isRd;
    cmd_next.wr = isWr;
    cmd_next.pre = isPre;
    cmd_next.preAll = isPre && apBit; // RL10
    cmd_next.autoPre = isAccess && apBit; // RL8 RL9
    if (isAct || isAccess || isPre) begin
      cmd_next.bank = bankAddr; // RL11
    end
    if (isAct) begin
      cmd_next.row = rowAddr; // RL6
    end
    if (isAccess) begin
      cmd_next.col = colAddr; // RL7
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_reg <= DEC_IDLE;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  // ==========================================================================
  // Per-bank state and auto-precharge timers
  // Timers keep running whatever chip select does, so a burst in flight finishes.
  logic [NUM_BANKS-1:0] bankOpen_reg;
  logic [NUM_BANKS-1:0] bankOpen_next;
  logic [CW-1:0] apCount_reg [NUM_BANKS];
  logic [CW-1:0] apCount_next [NUM_BANKS];

  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      wire apLoad = isAccess && apBit && bankHit[b]; // RL8
      wire apExpire = (apCount_reg[b] == AP_ONE);
      wire preHit = isPre && (apBit || bankHit[b]); // RL10
      // A new activate wins over a closing event in the same cycle.
      assign bankOpen_next[b] = (isAct && bankHit[b]) ? 1'b1 :
                                (preHit || apExpire) ? 1'b0 : bankOpen_reg[b]; // RL8 RL10
      // Without the flag the timer stays idle and the bank stays open.
      assign apCount_next[b] = apLoad ? AP_LOAD :
                               (apCount_reg[b] != AP_ZERO) ? apCount_reg[b] - AP_ONE :
                               AP_ZERO; // RL9
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      bankOpen_reg <= BANKS_CLOSED;
      apCount_reg <= '{default: AP_ZERO};
    end else begin
      bankOpen_reg <= bankOpen_next;
      apCount_reg <= apCount_next;
    end
  end

  // ==========================================================================
  // Write mask
  logic beatKeep_reg;
  logic beatDiscard_reg;

  // A masked beat is dropped; the controller must keep the mask aligned to data.
  always_ff @(posedge clk) begin
    if (rst) begin
      beatKeep_reg <= 1'b0;
      beatDiscard_reg <= 1'b0;
    end else begin
      beatKeep_reg <= beatS2_reg && !dmS2_reg; // RL12
      beatDiscard_reg <= beatS2_reg && dmS2_reg; // RL12
    end
  end

  // ==========================================================================
  // Outputs
  logic clkActive_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      clkActive_reg <= 1'b0;
    end else begin
      clkActive_reg <= ckeHigh; // RL2
    end
  end

  assign cmdOut = cmd_reg;
  assign bankOpen = bankOpen_reg;
  assign pwrState = pwrState_reg;
  assign clkActive = clkActive_reg;
  assign beatKeep = beatKeep_reg;
  assign beatDiscard = beatDiscard_reg;

  // ==========================================================================
  // Checks
  // Checks sample the second synchroniser stage, the values the decoder acts on.
  sequence s_apAccess(int unsigned bk);
    isAccess && apBit && (bankAddr == BA_W'(bk));
  endsequence

  sequence s_quietBank(int unsigned bk);
    !(decodeEn && bankHit[bk]) && !isPre;
  endsequence

  AST_DECODER_OFF: assert property (@(posedge clk) disable iff (rst) // RL3
    (pinsS2_reg.csN || !ckeHigh) |=> !(cmd_reg.act || cmd_reg.rd || cmd_reg.wr || cmd_reg.pre))
    else $error("Command accepted while decoder disabled.");

  AST_CKE_STATE: assert property (@(posedge clk) disable iff (rst) // RL2
    $fell(ckeHigh) && (pwrState_reg == PWR_ACTIVE) |=>
      (pwrState_reg != PWR_ACTIVE) && !clkActive_reg)
    else $error("CKE low did not leave the active state.");

  AST_CMD_SELECT: assert property (@(posedge clk) disable iff (rst) // RL5
    decodeEn && (cmdCode == CMD_WRITE) |=> cmd_reg.wr && !cmd_reg.rd && !cmd_reg.act)
    else $error("Write code did not select the write command.");

  AST_ACT_ROW: assert property (@(posedge clk) disable iff (rst) // RL6
    isAct |=> cmd_reg.act && (cmd_reg.row == $past(pinsS2_reg.addr)) && bankOpen_reg[cmd_reg.bank])
    else $error("Activate row address or bank state wrong.");

  AST_ACCESS_COL: assert property (@(posedge clk) disable iff (rst) // RL7
    isAccess |=> (cmd_reg.col == $past(pinsS2_reg.addr[COL_W-1:0])))
    else $error("Column address not taken from low address bits.");

  AST_AP_CLOSE: assert property (@(posedge clk) disable iff (rst) // RL8
    s_apAccess(0) ##1 s_quietBank(0) [*1] |-> ##[1:AP_MAX] !bankOpen_reg[0])
    else $error("Auto-precharge did not close bank zero after the burst.");

  AST_NO_AP_OPEN: assert property (@(posedge clk) disable iff (rst) // RL9
    isAccess && !apBit && bankOpen_reg[bankAddr] && (apCount_reg[bankAddr] == AP_ZERO) &&
      !isPre |=> !cmd_reg.autoPre && bankOpen_reg[cmd_reg.bank])
    else $error("Bank closed without the auto-precharge flag.");

  AST_PRE_ALL: assert property (@(posedge clk) disable iff (rst) // RL10
    isPre && apBit |=> cmd_reg.preAll && (bankOpen_reg == BANKS_CLOSED))
    else $error("Precharge-all left a bank open.");

  AST_BANK_SEL: assert property (@(posedge clk) disable iff (rst) // RL11
    (isAct || isAccess || isPre) |=> (cmd_reg.bank == $past(pinsS2_reg.bank)))
    else $error("Bank select not taken from bank address.");

  AST_MASK: assert property (@(posedge clk) disable iff (rst) // RL12
    beatS2_reg && dmS2_reg |=> beatDiscard_reg && !beatKeep_reg)
    else $error("Masked beat was not discarded.");

  AST_MASK_KEEP: assert property (@(posedge clk) disable iff (rst) // RL12
    beatS2_reg && !dmS2_reg |=> beatKeep_reg && !beatDiscard_reg)
    else $error("Unmasked beat was not kept.");

  // Further checks on bank closing, timers and the clock enable path.
  AST_PRE_ONE: assert property (@(posedge clk) disable iff (rst) // RL10
    isPre && !apBit |=> !cmd_reg.preAll && !bankOpen_reg[cmd_reg.bank])
    else $error("Single-bank precharge left its bank open.");

  AST_AP_FLAG: assert property (@(posedge clk) disable iff (rst) // RL8
    isAccess && apBit |=> cmd_reg.autoPre && (apCount_reg[cmd_reg.bank] == AP_LOAD))
    else $error("Auto-precharge flag did not start the bank timer.");

  AST_TIMER_RUNS: assert property (@(posedge clk) disable iff (rst) // RL4
    !decodeEn && (apCount_reg[0] != AP_ZERO) |=>
      (apCount_reg[0] == $past(apCount_reg[0]) - AP_ONE))
    else $error("Bank timer stalled while the decoder was disabled.");

  AST_CKE_LOW: assert property (@(posedge clk) disable iff (rst) // RL2
    !ckeHigh |=> !clkActive_reg)
    else $error("Clock reported active while CKE was low.");

  AST_CKE_WAKE: assert property (@(posedge clk) disable iff (rst) // RL2
    $rose(ckeHigh) && (pwrState_reg != PWR_ACTIVE) |=> (pwrState_reg == PWR_ACTIVE) && clkActive_reg)
    else $error("CKE high did not return to the active state.");

endmodule // ddr2_cmd_addr_decode

`default_nettype wire

// ### ddr2_cmd_pkg.sv
// Purpose: Shared types and constants for the DDR2 command and address input stage.
// Assumes: x8 organisation, eight banks, fourteen row bits and ten column bits.
// Notes: Command codes are the levels of RAS, CAS and WE, all active low.
// Behaviour
// (RL1) Command and address pins are captured on the rising clock edge.
// (RL2) Clock counts as active only while CKE is high; low enters power-down or self-refresh.
// (RL3) Command decoder is enabled only while chip select samples low.
// (RL4) With decoder disabled, new commands are ignored; running operations finish.
// (RL5) RAS, CAS and WE levels together select the command executed.
// (RL6) Activate takes all fourteen address bits as the row address.
// (RL7) Read or write takes address bits zero to nine as the column.
// (RL8) Read or write with bit ten high precharges the bank after the burst.
// (RL9) Read or write with bit ten low leaves the bank open.
// (RL10) Precharge with bit ten high closes all banks, else only the addressed one.
// (RL11) The three bank address bits pick one of eight banks.
// (RL12) Write beats with the mask sampled high are discarded.
// (RL13) Controller activates a row before access and precharges before a new row.
package ddr2_cmd_pkg;

  // ==========================================================================
  // Geometry and timing
  localparam int NUM_BANKS = 8;
  localparam int BA_W = 3;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;
  localparam int AP_DELAY_CYCLES = 4;

  // ==========================================================================
  // Command codes on {RAS, CAS, WE}
  typedef enum logic [2:0] {
    CMD_MODE = 3'b000,
    CMD_REFRESH = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ACTIVATE = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_READ = 3'b101,
    CMD_RESERVED = 3'b110,
    CMD_NOP = 3'b111
  } cmd_t;

  // Clock state as seen through CKE.
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_SELF_REFRESH = 2'b10
  } pwr_state_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [BA_W-1:0] bank;
    logic [ROW_W-1:0] addr;
  } cmd_pins_t;

  typedef struct packed {
    logic act;
    logic rd;
    logic wr;
    logic pre;
    logic preAll;
    logic autoPre;
    logic [BA_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } dec_cmd_t;

  // ==========================================================================
  // Values after reset
  localparam cmd_pins_t PINS_IDLE = '{cke: 1'b0, csN: 1'b1, rasN: 1'b1, casN: 1'b1,
                                      weN: 1'b1, bank: 3'h0, addr: 14'h0000};
  localparam dec_cmd_t DEC_IDLE = '0;
  localparam logic [NUM_BANKS-1:0] BANKS_CLOSED = 8'h00;

endpackage

// ### ddr2_ctrl_model.sv
// Purpose: Controller-side model that drives the command and address pins.
// Assumes: Pins change only at the falling clock edge, one command cycle per call.
// Notes: Between commands the address bus shows inverted values, not the last ones.
`timescale 1ns/1ns
`default_nettype none
module ddr2_ctrl_model (
  // Clock
  input wire logic clk,
  // Pins toward the device
  output var ddr2_cmd_pkg::cmd_pins_t pins
);
  import ddr2_cmd_pkg::*;
  // ==========================================================================
  // Command issue
  // Idle with the clock enabled so that the device leaves power-down after reset.
  initial begin
    pins = '{cke: 1'b1, csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, bank: 3'h0, addr: 14'h0};
  end
  // Drive one command around a rising edge, then deselect; clock enable stays as given.
  task automatic issue(input cmd_t c, input logic [2:0] ba, input logic [13:0] a,
                       input logic cs, input logic ce);
    @(negedge clk);
    pins <= '{cke: ce, csN: cs, rasN: c[2], casN: c[1], weN: c[0], bank: ba, addr: a};
    @(negedge clk);
    pins <= '{cke: ce, csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, bank: ~ba, addr: ~a};
  endtask
endmodule // ddr2_ctrl_model
`default_nettype wire

// ### test_ddr2_cmd_addr_decode.sv
// Purpose: Self-checking bench for the command and address input stage.
// Assumes: Three-edge latency from pins to decoded outputs.
// Notes: A short auto-precharge count keeps the run brief.
`timescale 1ns/1ns
`default_nettype none
module test_ddr2_cmd_addr_decode;
  import ddr2_cmd_pkg::*;
  localparam int BURST = 3;
  logic clk;
  logic rst;
  logic dm;
  logic beatStrobe;
  logic clkActive;
  logic beatKeep;
  logic beatDiscard;
  logic [7:0] bankOpen;
  cmd_pins_t pins;
  dec_cmd_t cmdOut;
  pwr_state_t pwrState;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  // ==========================================================================
  // Device and controller
  ddr2_cmd_addr_decode #(.BURST_CYCLES(BURST)) i_ddr2_cmd_addr_decode (.clk(clk), .rst(rst),
    .pins(pins), .dm(dm), .beatStrobe(beatStrobe), .cmdOut(cmdOut), .bankOpen(bankOpen),
    .pwrState(pwrState), .clkActive(clkActive), .beatKeep(beatKeep), .beatDiscard(beatDiscard));
  ddr2_ctrl_model i_ddr2_ctrl_model (.clk(clk), .pins(pins));
  // Free-running clock at 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard; the whole run needs fewer than two hundred cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end
  // ==========================================================================
  // Helpers
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Issue one command and return in the cycle where its decoded pulse stands.
  task automatic send(input cmd_t c, input logic [2:0] ba, input logic [13:0] a,
                      input logic cs, input logic ce);
    i_ddr2_ctrl_model.issue(c, ba, a, cs, ce);
    @(posedge clk);
    @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // Every code with the decoder enabled, then again deselected.
  task automatic t_codes();
    cmd_t c;
    logic [3:0] e;
    for (int k = 0; k < 16; k++) begin
      c = cmd_t'(k[2:0]);
      e = (c == CMD_ACTIVATE) ? 4'h8 : (c == CMD_READ) ? 4'h4 : (c == CMD_WRITE) ? 4'h2 :
          (c == CMD_PRECHARGE) ? 4'h1 : 4'h0;
      send(c, 3'h0, 14'h0, k[3], 1'b1);
      chk("strobes", 16'(k[3] ? 4'h0 : e), 16'({cmdOut.act, cmdOut.rd, cmdOut.wr, cmdOut.pre}));
    end
    $display("test codes done");
  endtask
  // Close all banks, then open each with its own row.
  task automatic t_act();
    send(CMD_PRECHARGE, 3'h4, 14'h0400, 1'b0, 1'b1);
    chk("closed", 16'h0, 16'(bankOpen));
    for (int b = 0; b < 8; b++) begin
      send(CMD_ACTIVATE, 3'(b), {3'(b), 8'ha5, 3'(b)}, 1'b0, 1'b1);
      chk("act", 16'h1, 16'(cmdOut.act));
      chk("bank", 16'(b), 16'(cmdOut.bank));
      chk("row", 16'({3'(b), 8'ha5, 3'(b)}), 16'(cmdOut.row));
      chk("open", 16'((2 << b) - 1), 16'(bankOpen));
    end
    $display("test activate done");
  endtask
  // Read without and write with auto-precharge; a deselected activate must not reopen.
  task automatic t_rw();
    send(CMD_READ, 3'h3, 14'h3b55, 1'b0, 1'b1);
    chk("col", 16'h0355, 16'(cmdOut.col));
    chk("rd", 16'h2, 16'({cmdOut.rd, cmdOut.autoPre}));
    repeat (BURST + 2) @(posedge clk);
    #1;
    chk("open", 16'hff, 16'(bankOpen));
    send(CMD_WRITE, 3'h5, 14'h06aa, 1'b0, 1'b1);
    chk("col", 16'h02aa, 16'(cmdOut.col));
    chk("wr", 16'h3, 16'({cmdOut.wr, cmdOut.autoPre}));
    chk("open", 16'hff, 16'(bankOpen));
    i_ddr2_ctrl_model.issue(CMD_ACTIVATE, 3'h5, 14'h0, 1'b1, 1'b1);
    repeat (BURST) @(posedge clk);
    #1;
    chk("open", 16'hdf, 16'(bankOpen));
    send(CMD_READ, 3'h0, 14'h0400, 1'b0, 1'b1);
    chk("rd", 16'h3, 16'({cmdOut.rd, cmdOut.autoPre}));
    repeat (BURST) @(posedge clk);
    #1;
    chk("open", 16'hde, 16'(bankOpen));
    $display("test read write done");
  endtask
  // Single-bank precharge, then all banks with an unrelated bank address.
  task automatic t_pre();
    send(CMD_PRECHARGE, 3'h6, 14'h3bff, 1'b0, 1'b1);
    chk("pre", 16'h2, 16'({cmdOut.pre, cmdOut.preAll}));
    chk("open", 16'h9e, 16'(bankOpen));
    send(CMD_PRECHARGE, 3'h2, 14'h0400, 1'b0, 1'b1);
    chk("pre", 16'h3, 16'({cmdOut.pre, cmdOut.preAll}));
    chk("open", 16'h0, 16'(bankOpen));
    $display("test precharge done");
  endtask
  // Clock enable low: power-down ignores commands; refresh code enters self-refresh.
  task automatic t_cke();
    send(CMD_ACTIVATE, 3'h1, 14'h0, 1'b0, 1'b0);
    chk("act", 16'h0, 16'(cmdOut.act));
    chk("pwr", 16'(PWR_DOWN), {clkActive, 13'h0, pwrState});
    send(CMD_NOP, 3'h0, 14'h0, 1'b1, 1'b1);
    chk("pwr", 16'h8000 | 16'(PWR_ACTIVE), {clkActive, 13'h0, pwrState});
    chk("open", 16'h0, 16'(bankOpen));
    send(CMD_REFRESH, 3'h0, 14'h0, 1'b0, 1'b0);
    chk("pwr", 16'(PWR_SELF_REFRESH), {clkActive, 13'h0, pwrState});
    send(CMD_NOP, 3'h0, 14'h0, 1'b1, 1'b1);
    $display("test clock enable done");
  endtask
  // A masked beat followed directly by a kept one.
  task automatic t_mask();
    @(negedge clk);
    beatStrobe = 1'b1;
    dm = 1'b1;
    @(negedge clk);
    dm = 1'b0;
    @(negedge clk);
    beatStrobe = 1'b0;
    @(posedge clk);
    #1;
    chk("beat", 16'h1, 16'({beatKeep, beatDiscard}));
    @(posedge clk);
    #1;
    chk("beat", 16'h2, 16'({beatKeep, beatDiscard}));
    $display("test mask done");
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    dm = 1'b0;
    beatStrobe = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_codes();
    t_act();
    t_rw();
    t_pre();
    t_cke();
    t_mask();
    results();
  end
endmodule // test_ddr2_cmd_addr_decode
`default_nettype wire
